//--- pkg/sdram_cmd_pkg.sv
// constants and carrier types for the synchronous dram command front end
package sdram_cmd_pkg;
   localparam int ADDR_W      = 12;
   localparam int BANK_W      = 2;
   localparam int COL_W       = 8;
   localparam int DATA_W      = 16;
   localparam int NUM_BANKS   = 4;
   localparam int MODE_W      = 14;
   localparam int AP_BIT      = 10;
   // mode word fields
   localparam int BL_LSB      = 0;
   localparam int BT_BIT      = 3;
   localparam int RL_LSB      = 4;
   localparam int OPM_LSB     = 7;
   localparam int WBM_BIT     = 9;
   localparam int SEL_LSB     = 12;
   localparam logic [1:0] SEL_BASE = 2'h0;
   localparam logic [1:0] SEL_EXT  = 2'h2;
   localparam logic [13:0] MODE_RST = 14'h0000;
   localparam logic [11:0] EMODE_RST = 12'h000;
   // command codes {cs_n, ras_n, cas_n, we_n}
   localparam logic [3:0] CMD_NOP   = 4'h7;
   localparam logic [3:0] CMD_ACT   = 4'h3;
   localparam logic [3:0] CMD_RD    = 4'h5;
   localparam logic [3:0] CMD_WR    = 4'h4;
   localparam logic [3:0] CMD_PRE   = 4'h2;
   localparam logic [3:0] CMD_REF   = 4'h1;
   localparam logic [3:0] CMD_LMR   = 4'h0;
   localparam logic [3:0] CMD_BST   = 4'h6;

   typedef enum logic [2:0] {
      OP_NONE = 3'h0,
      OP_ACT  = 3'h1,
      OP_RD   = 3'h3,
      OP_WR   = 3'h2,
      OP_PRE  = 3'h6,
      OP_REF  = 3'h7,
      OP_LMR  = 3'h5
   } op_t;

   typedef struct packed {
      logic        cs_n;
      logic        ras_n;
      logic        cas_n;
      logic        we_n;
      logic [1:0]  bank;
      logic [11:0] addr;
   } cmd_pins_t;

   typedef struct packed {
      logic [2:0]  burst_len;
      logic        burst_type;
      logic [2:0]  read_lat;
      logic [1:0]  op_mode;
      logic        write_single;
   } mode_fields_t;
endpackage

//--- verilog/sdram_cmd_decode.sv
// command decoder for registered control pins
`timescale 1ns/1ps
module sdram_cmd_decode
   import sdram_cmd_pkg::*;
(
   // registered pins
   input  wire cmd_pins_t i_pins,
   // decoded command
   output op_t            o_op
);
   always_comb begin
      // a high chip select masks everything
      if (i_pins.cs_n) begin
         o_op = OP_NONE;
      end else begin
         case ({i_pins.cs_n, i_pins.ras_n, i_pins.cas_n,
                i_pins.we_n})
            CMD_ACT: o_op = OP_ACT;
            CMD_RD:  o_op = OP_RD;
            CMD_WR:  o_op = OP_WR;
            CMD_PRE: o_op = OP_PRE;
            CMD_REF: o_op = OP_REF;
            CMD_LMR: o_op = OP_LMR;
            default: o_op = OP_NONE;
         endcase
      end
   end
endmodule // sdram_cmd_decode

//--- verilog/sdram_mode_decode.sv
// field split of the stored mode word
`timescale 1ns/1ps
module sdram_mode_decode
   import sdram_cmd_pkg::*;
(
   // stored word
   input  wire logic [MODE_W-1:0] i_mode,
   // fields
   output mode_fields_t           o_fields
);
   always_comb begin
      o_fields.burst_len    = i_mode[BL_LSB +: 3];
      o_fields.burst_type   = i_mode[BT_BIT];
      o_fields.read_lat     = i_mode[RL_LSB +: 3];
      o_fields.op_mode      = i_mode[OPM_LSB +: 2];
      o_fields.write_single = i_mode[WBM_BIT];
   end
endmodule // sdram_mode_decode

//--- verilog/sdram_cmd_front.sv
// command front end: addressing, bank state and mode register storage
//
// Functional notes
// - all pins are captured on the rising clock edge only.
// - bank select picks the bank for active, read, write, precharge.
// - in a mode load, bank select picks base or extended register.
// - active captures all twelve address lines as row address.
// - read or write takes the low eight address lines as column.
// - each bank is 4096 rows by 256 columns of 16-bit words.
// - address bit ten on read or write requests auto precharge.
// - precharge with bit ten high closes all banks, else one.
// - address lines carry the opcode stored into the mode register.
// - mode register is undefined until loaded by the controller; here reset sets it to MODE_RST (zero) with o_mode_loaded low.
// - mode fields: length, type, latency, op mode, write burst mode.
// - both top mode bits zero select the base mode register.
// - mode register holds its value until written again.
// - registered high chip select masks every command.
// - commands are coded by chip select and three strobes.
`timescale 1ns/1ps
module sdram_cmd_front
   import sdram_cmd_pkg::*;
#(
   parameter int ROWS = 4096,
   parameter int COLS = 256
) (
   // clock and reset
   input  wire logic              i_clk_sys,
   input  wire logic              i_sys_rst,
   // command pins
   input  wire logic              i_cs_n,
   input  wire logic              i_ras_n,
   input  wire logic              i_cas_n,
   input  wire logic              i_we_n,
   input  wire logic              i_bank_select_0,
   input  wire logic              i_bank_select_1,
   input  wire logic [ADDR_W-1:0] i_row_col_addr_lines,
   // stored mode state
   output logic [MODE_W-1:0]      o_mode_register,
   output logic [ADDR_W-1:0]      o_ext_mode_register,
   output logic                   o_mode_loaded,
   // bank state
   output logic [NUM_BANKS-1:0]   o_bank_open,
   output logic                   o_all_idle,
   // last column access
   output logic                   o_access_valid,
   output logic                   o_access_write,
   output logic [BANK_W-1:0]      o_access_bank,
   output logic [ADDR_W-1:0]      o_access_row,
   output logic [COL_W-1:0]       o_access_col,
   output logic                   o_access_auto_pre,
   output logic [2:0]             o_access_burst_len,
   output logic                   o_access_burst_type,
   output logic [2:0]             o_access_read_lat,
   // refresh count since last reset
   output logic [1:0]             o_refresh_count
);
   typedef struct packed {
      cmd_pins_t                           pins;
      logic [MODE_W-1:0]                   mode;
      logic [ADDR_W-1:0]                   emode;
      logic                                loaded;
      logic [NUM_BANKS-1:0]                open;
      logic [NUM_BANKS-1:0][ADDR_W-1:0]    rows;
      logic                                acc_v;
      logic                                acc_w;
      logic [BANK_W-1:0]                   acc_bank;
      logic [ADDR_W-1:0]                   acc_row;
      logic [COL_W-1:0]                    acc_col;
      logic                                acc_ap;
      logic [2:0]                          acc_bl;
      logic                                acc_bt;
      logic [2:0]                          acc_rl;
      logic [1:0]                          refs;
      logic                                idle;
      logic                                run;
   } state_t;

   state_t       st_q;
   state_t       st_d;
   op_t          op;
   mode_fields_t mf;
   logic [BANK_W-1:0] bk;

   sdram_cmd_decode u_dec (
      .i_pins (st_q.pins),
      .o_op   (op)
   );

   sdram_mode_decode u_mode (
      .i_mode   (st_q.mode),
      .o_fields (mf)
   );

   // row index is ADDR_W bits wide, columns COL_W: 4096 x 256 words
   // of DATA_W bits each; the array lives outside this block
   assign bk = st_q.pins.bank;

   always_comb begin
      st_d = st_q;
      // pins are sampled here and acted on one edge later
      st_d.pins.cs_n  = i_cs_n;
      st_d.pins.ras_n = i_ras_n;
      st_d.pins.cas_n = i_cas_n;
      st_d.pins.we_n  = i_we_n;
      st_d.pins.bank  = {i_bank_select_1, i_bank_select_0};
      st_d.pins.addr  = i_row_col_addr_lines;
      st_d.acc_v      = 1'b0;
      case (op)
         OP_ACT: begin
            st_d.open[bk] = 1'b1;
            st_d.rows[bk] = st_q.pins.addr;
         end
         OP_RD,
         OP_WR: begin
            // access to a closed bank is the controller's fault;
            // it is reported anyway so a checker can see it
            st_d.acc_v    = 1'b1;
            st_d.acc_w    = (op == OP_WR);
            st_d.acc_bank = bk;
            st_d.acc_row  = st_q.rows[bk];
            st_d.acc_col  = st_q.pins.addr[COL_W-1:0];
            st_d.acc_ap   = st_q.pins.addr[AP_BIT];
            st_d.acc_bl   = (op == OP_WR && mf.write_single) ?
                            3'h0 : mf.burst_len;
            st_d.acc_bt   = mf.burst_type;
            st_d.acc_rl   = mf.read_lat;
            // auto precharge closes the row; burst timing not modelled
            if (st_q.pins.addr[AP_BIT]) begin
               st_d.open[bk] = 1'b0;
            end
         end
         OP_PRE: begin
            if (st_q.pins.addr[AP_BIT]) begin
               st_d.open = '0;
            end else begin
               st_d.open[bk] = 1'b0;
            end
         end
         OP_REF: begin
            if (st_q.refs != 2'h3) begin
               st_d.refs = st_q.refs + 2'h1;
            end
         end
         OP_LMR: begin
            // bank select carries mode bits 12 and 13
            if (bk == SEL_BASE) begin
               st_d.mode   = {bk, st_q.pins.addr};
               st_d.loaded = 1'b1;
            end else if (bk == SEL_EXT) begin
               st_d.emode = st_q.pins.addr;
            end
         end
         default: begin
         end
      endcase
      // idle is kept in a flop so the output never glitches
      st_d.idle = ~|st_d.open;
      st_d.run  = 1'b1;
   end

   // no power-on reset exists on the device; the reset here only
   // brings simulation to a known state, mode stays unloaded
   always_ff @(posedge i_clk_sys) begin
      if (i_sys_rst) begin
         st_q          <= '0;
         st_q.pins     <= {4'hf, 2'h0, 12'h000};
         st_q.mode     <= MODE_RST;
         st_q.emode    <= EMODE_RST;
         st_q.idle     <= 1'b1;
      end else begin
         st_q <= st_d;
      end
   end

   always_comb begin
      o_mode_register     = st_q.mode;
      o_ext_mode_register = st_q.emode;
      o_mode_loaded       = st_q.loaded;
      o_bank_open         = st_q.open;
      o_all_idle          = st_q.idle;
      o_access_valid      = st_q.acc_v;
      o_access_write      = st_q.acc_w;
      o_access_bank       = st_q.acc_bank;
      o_access_row        = st_q.acc_row;
      o_access_col        = st_q.acc_col;
      o_access_auto_pre   = st_q.acc_ap;
      o_access_burst_len  = st_q.acc_bl;
      o_access_burst_type = st_q.acc_bt;
      o_access_read_lat   = st_q.acc_rl;
      o_refresh_count     = st_q.refs;
   end

   // assertions; run stays low for one edge after reset release

   property p_cs_mask;
      @(posedge i_clk_sys) disable iff (i_sys_rst)
      (st_q.run && i_cs_n) |=> ##1 $stable(st_q.mode) && !st_q.acc_v;
   endproperty
   a_cs_mask: assert property (p_cs_mask)
      else $error("command accepted with chip select high");

   property p_act_row;
      @(posedge i_clk_sys) disable iff (i_sys_rst)
      (op == OP_ACT) |=> o_bank_open[$past(bk)]
         && st_q.rows[$past(bk)] == $past(st_q.pins.addr);
   endproperty
   a_act_row: assert property (p_act_row)
      else $error("active did not open the bank");

   property p_col;
      @(posedge i_clk_sys) disable iff (i_sys_rst)
      (op == OP_RD || op == OP_WR) |=> o_access_valid
         && o_access_col == $past(st_q.pins.addr[COL_W-1:0])
         && o_access_bank == $past(bk);
   endproperty
   a_col: assert property (p_col)
      else $error("column or bank of access wrong");

   property p_ap;
      @(posedge i_clk_sys) disable iff (i_sys_rst)
      (op == OP_RD || op == OP_WR) |=>
         o_access_auto_pre == $past(st_q.pins.addr[AP_BIT]);
   endproperty
   a_ap: assert property (p_ap)
      else $error("auto precharge flag wrong");

   property p_pre_all;
      @(posedge i_clk_sys) disable iff (i_sys_rst)
      (op == OP_PRE && st_q.pins.addr[AP_BIT]) |=> o_all_idle;
   endproperty
   a_pre_all: assert property (p_pre_all)
      else $error("precharge all left a bank open");

   property p_pre_one;
      @(posedge i_clk_sys) disable iff (i_sys_rst)
      (op == OP_PRE && !st_q.pins.addr[AP_BIT]) |=>
         !o_bank_open[$past(bk)];
   endproperty
   a_pre_one: assert property (p_pre_one)
      else $error("selected bank not precharged");

   property p_lmr;
      @(posedge i_clk_sys) disable iff (i_sys_rst)
      (op == OP_LMR && bk == SEL_BASE) |=>
         o_mode_register == {2'h0, $past(st_q.pins.addr)}
         && o_mode_loaded;
   endproperty
   a_lmr: assert property (p_lmr)
      else $error("mode load not stored");

   property p_ext;
      @(posedge i_clk_sys) disable iff (i_sys_rst)
      (op == OP_LMR && bk != SEL_BASE) |=> $stable(o_mode_register);
   endproperty
   a_ext: assert property (p_ext)
      else $error("extended load touched base register");

   property p_hold;
      @(posedge i_clk_sys) disable iff (i_sys_rst)
      (st_q.run && op != OP_LMR) |=> $stable(o_mode_register);
   endproperty
   a_hold: assert property (p_hold)
      else $error("mode register changed without a load");

   property p_wbm;
      @(posedge i_clk_sys) disable iff (i_sys_rst)
      (op == OP_WR && mf.write_single) |=> o_access_burst_len == 3'h0;
   endproperty
   a_wbm: assert property (p_wbm)
      else $error("single write mode ignored");
endmodule // sdram_cmd_front

//--- tb/sdram_ctrl_model.sv
// controller model that drives the command pins of the dram front end
`timescale 1ns/1ps
module sdram_ctrl_model
   import sdram_cmd_pkg::*;
#(
   parameter int WAIT_CYC = 20
) (
   // clock
   input  wire logic              i_clk_sys,
   // command pins
   output logic                   o_cs_n,
   output logic                   o_ras_n,
   output logic                   o_cas_n,
   output logic                   o_we_n,
   output logic                   o_bank_select_0,
   output logic                   o_bank_select_1,
   output logic [ADDR_W-1:0]      o_row_col_addr_lines
);
   initial begin
      {o_cs_n, o_ras_n, o_cas_n, o_we_n} = CMD_NOP;
      {o_bank_select_1, o_bank_select_0} = 2'h0;
      o_row_col_addr_lines = 12'h000;
   end

   // one command for one clock, pins move 1 ns after the edge
   task automatic send(input logic [3:0] cmd, input logic [1:0] ba,
                       input logic [11:0] a);
      @(posedge i_clk_sys);
      #1;
      {o_cs_n, o_ras_n, o_cas_n, o_we_n} = cmd;
      {o_bank_select_1, o_bank_select_0} = ba;
      o_row_col_addr_lines = a;
      @(posedge i_clk_sys);
      #1;
      {o_cs_n, o_ras_n, o_cas_n, o_we_n} = CMD_NOP;
      // address means nothing under nop, so keep it from looking stable
      o_row_col_addr_lines = ~a;
      repeat (3) @(posedge i_clk_sys);
      #1;
   endtask

   // shortened power-up wait, then precharge all and two refreshes
   task automatic power_up();
      repeat (WAIT_CYC) @(posedge i_clk_sys);
      send(CMD_PRE, 2'h0, 12'h400);
      send(CMD_REF, 2'h0, 12'h000);
      send(CMD_REF, 2'h0, 12'h000);
   endtask
endmodule // sdram_ctrl_model

//--- tb/test_sdram_cmd_front.sv
// self-checking bench for the dram command front end
`timescale 1ns/1ps
module test_sdram_cmd_front;
   import sdram_cmd_pkg::*;
   logic              clk;
   logic              rst;
   logic              cs_n, ras_n, cas_n, we_n, ba0, ba1;
   logic [11:0]       addr;
   logic [13:0]       mode;
   logic [11:0]       emode;
   logic              loaded, idle, av, aw, aap, abt;
   logic [3:0]        open;
   logic [1:0]        ab, refc;
   logic [11:0]       arow;
   logic [7:0]        acol;
   logic [2:0]        abl, arl;
   logic [1:0]        c_b;
   logic [11:0]       c_row;
   logic [7:0]        c_col;
   logic [2:0]        c_bl, c_rl;
   logic              c_w, c_ap, c_bt;
   logic [11:0]       rows [4] = '{12'hfff, 12'h5a5, 12'h001, 12'h800};
   int                miscompares, checks_done, acc_cnt, n;

   sdram_ctrl_model #(.WAIT_CYC(20)) ctrl_u (.i_clk_sys(clk),
      .o_cs_n(cs_n), .o_ras_n(ras_n), .o_cas_n(cas_n), .o_we_n(we_n),
      .o_bank_select_0(ba0), .o_bank_select_1(ba1),
      .o_row_col_addr_lines(addr));

   sdram_cmd_front dut_u (.i_clk_sys(clk), .i_sys_rst(rst),
      .i_cs_n(cs_n), .i_ras_n(ras_n), .i_cas_n(cas_n), .i_we_n(we_n),
      .i_bank_select_0(ba0), .i_bank_select_1(ba1),
      .i_row_col_addr_lines(addr), .o_mode_register(mode),
      .o_ext_mode_register(emode), .o_mode_loaded(loaded),
      .o_bank_open(open), .o_all_idle(idle), .o_access_valid(av),
      .o_access_write(aw), .o_access_bank(ab), .o_access_row(arow),
      .o_access_col(acol), .o_access_auto_pre(aap),
      .o_access_burst_len(abl), .o_access_burst_type(abt),
      .o_access_read_lat(arl), .o_refresh_count(refc));

   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end

   // latch each access pulse mid-cycle, where the outputs have settled
   always @(negedge clk) begin
      if (av === 1'b1) begin
         acc_cnt++;
         {c_w, c_b, c_row, c_col, c_ap} = {aw, ab, arow, acol, aap};
         {c_bl, c_bt, c_rl} = {abl, abt, arl};
      end
   end

   task automatic check(input string what, input logic [15:0] seen,
                        input logic [15:0] exp);
      checks_done++;
      if (seen !== exp) begin
         miscompares++;
         $display("unexpected %s: expected %h seen %h", what, exp, seen);
      end
   endtask

   task automatic chk_acc(input logic w, input logic [1:0] b,
                          input logic [11:0] r, input logic [7:0] c,
                          input logic ap, input logic [2:0] bl);
      check("access count", 16'(acc_cnt), 16'(n + 1));
      check("access write", 16'(c_w), 16'(w));
      check("access bank", 16'(c_b), 16'(b));
      check("access row", 16'(c_row), 16'(r));
      check("access col", 16'(c_col), 16'(c));
      check("auto pre", 16'(c_ap), 16'(ap));
      check("burst len", 16'(c_bl), 16'(bl));
      check("burst type", 16'(c_bt), 16'h1);
      check("read lat", 16'(c_rl), 16'h3);
   endtask

   task automatic final_report();
      $display("checks %0d miscompares %0d", checks_done, miscompares);
      if (miscompares == 0 && checks_done > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask

   initial begin
      #20000;
      miscompares++;
      $display("watchdog expired");
      final_report();
   end

   initial begin
      rst = 1'b1;
      repeat (16) @(posedge clk);
      #1;
      rst = 1'b0;
      check("mode reset", 16'(mode), 16'h0);
      check("loaded reset", 16'(loaded), 16'h0);
      check("idle reset", 16'(idle), 16'h1);
      ctrl_u.power_up();
      check("refresh count", 16'(refc), 16'h2);
      check("idle after init", 16'(idle), 16'h1);
      $display("test init done");
      // reserved bits kept zero, loads only with all banks idle
      ctrl_u.send(CMD_LMR, SEL_BASE, 12'h032);
      check("mode base", 16'(mode), 16'h0032);
      check("loaded", 16'(loaded), 16'h1);
      ctrl_u.send(CMD_LMR, SEL_EXT, 12'h5a5);
      check("ext mode", 16'(emode), 16'h05a5);
      check("mode kept", 16'(mode), 16'h0032);
      ctrl_u.send(CMD_LMR, 2'h1, 12'hfff);
      check("ext refused", 16'(emode), 16'h05a5);
      check("mode refused", 16'(mode), 16'h0032);
      ctrl_u.send(CMD_LMR, SEL_BASE, 12'h23b);
      check("mode reload", 16'(mode), 16'h023b);
      $display("test mode done");
      ctrl_u.send(CMD_ACT | 4'h8, 2'h0, 12'h123);
      check("masked act", 16'(open), 16'h0);
      for (int i = 0; i < 4; i++) begin
         ctrl_u.send(CMD_ACT, 2'(i), rows[i]);
         check("open mask", 16'(open), 16'((2 << i) - 1));
      end
      $display("test activate done");
      n = acc_cnt;
      ctrl_u.send(CMD_RD, 2'h1, 12'hbc3);
      chk_acc(1'b0, 2'h1, 12'h5a5, 8'hc3, 1'b0, 3'h3);
      check("open after rd", 16'(open), 16'hf);
      n = acc_cnt;
      ctrl_u.send(CMD_WR, 2'h2, 12'h47e);
      chk_acc(1'b1, 2'h2, 12'h001, 8'h7e, 1'b1, 3'h0);
      check("open after wr", 16'(open), 16'hb);
      $display("test access done");
      ctrl_u.send(CMD_PRE, 2'h0, 12'h3ff);
      check("pre one", 16'(open), 16'ha);
      ctrl_u.send(CMD_PRE, 2'h3, 12'h400);
      check("pre all", 16'(open), 16'h0);
      check("idle", 16'(idle), 16'h1);
      ctrl_u.send(CMD_REF, 2'h0, 12'h000);
      ctrl_u.send(CMD_REF, 2'h0, 12'h000);
      check("refresh sat", 16'(refc), 16'h3);
      $display("test precharge done");
      final_report();
   end
endmodule // test_sdram_cmd_front
